// ---- lptx_map.vh ----
// Summary of operation
// - Three independent logical transmit ports feed one shared queuing unit.
// - Payload travels as one 64-bit word per data beat.
// - A discard seen anywhere during a packet drops the whole packet.
// - Ready is asserted only when a beat can be taken that cycle.
// - Ready is withheld while another port's packet is being enqueued.
// - Ready is withheld when fifteen packets wait at the packet's priority.
// - Ready is withheld when every packet buffer is occupied.
// - Once a packet starts, ready stays asserted until its last beat.
// - All transfers are timed on the single logical-layer clock.
// - A beat takes one cycle without flow control, longer otherwise.
`ifndef LPTX_MAP_VH
`define LPTX_MAP_VH
`define LPTX_NUM_PORTS 3
`define LPTX_DATA_W 64
`define LPTX_REM_W 3
`define LPTX_PRIO_W 2
`define LPTX_NUM_PRIO 4
`define LPTX_PRIO_LIMIT 4'hF
`define LPTX_PRIO_MSB 3
`define LPTX_NUM_BUFS 8
`define LPTX_CNT_W 4
`endif

// ---- lptx_port.v ----
`timescale 1ns/1ps
`include "lptx_map.vh"
// one logical transmit port: framing tracker and ready generation
module lptx_port (
	input wire clk_i,
	input wire rst_n_i,
	input wire source_valid_i,
	input wire first_beat_i,
	input wire last_beat_i,
	input wire discard_i,
	input wire [`LPTX_PRIO_W-1:0] prio_i,
	input wire grant_i,
	input wire can_start_i,
	output reg ready_o,
	output reg ready_n_o,
	output wire beat_o,
	output wire in_pkt_o,
	output wire commit_o,
	output wire drop_o,
	output wire [`LPTX_PRIO_W-1:0] pkt_prio_o
);
	reg in_pkt_q;
	reg in_pkt_d;
	reg dsc_q;
	reg dsc_d;
	reg [`LPTX_PRIO_W-1:0] prio_q;
	reg ready_d;
	wire beat;
	wire beat_dsc;
	assign beat = source_valid_i & ready_o;
	assign beat_dsc = dsc_q | discard_i;
	assign beat_o = beat;
	assign in_pkt_o = in_pkt_q;
	assign pkt_prio_o = prio_q;
	assign commit_o = beat & last_beat_i & ~beat_dsc & (in_pkt_q | first_beat_i);
	// discard during a packet drops it whole, even if the last beat is clean
	assign drop_o = beat & last_beat_i & beat_dsc;
	always @* begin
		in_pkt_d = in_pkt_q;
		dsc_d = dsc_q;
		if (beat) begin
			if (last_beat_i) begin
				in_pkt_d = 1'b0;
				dsc_d = 1'b0;
			end else begin
				in_pkt_d = 1'b1;
				dsc_d = beat_dsc;
			end
		end else if (in_pkt_q & discard_i) begin
			dsc_d = 1'b1;
		end
		// stall only at packet boundaries; mid-packet ready is held
		if (in_pkt_d) begin
			ready_d = 1'b1;
		end else begin
			ready_d = grant_i & can_start_i;
		end
	end
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			in_pkt_q <= 1'b0;
			dsc_q <= 1'b0;
			prio_q <= {`LPTX_PRIO_W{1'b0}};
			ready_o <= 1'b0;
			ready_n_o <= 1'b1;
		end else begin
			in_pkt_q <= in_pkt_d;
			dsc_q <= dsc_d;
			ready_o <= ready_d;
			// pin copy shares the internal flop's timing, so it is never late
			ready_n_o <= ~ready_d;
			if (beat & first_beat_i) begin
				prio_q <= prio_i;
			end
		end
	end
endmodule // lptx_port

// ---- lptx_ingress.v ----
`timescale 1ns/1ps
`include "lptx_map.vh"
// three transmit ports sharing one queuing unit
module lptx_ingress #(
	parameter NUM_BUFS = `LPTX_NUM_BUFS
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire [3*`LPTX_DATA_W-1:0] tx_port_payload_word_i,
	input wire [3*`LPTX_REM_W-1:0] tx_port_final_byte_count_i,
	input wire [2:0] tx_port_first_beat_mark_n_i,
	input wire [2:0] tx_port_last_beat_mark_n_i,
	input wire [2:0] tx_port_source_valid_n_i,
	input wire [2:0] tx_port_packet_discard_n_i,
	input wire [3:0] queue_release_i,
	input wire [`LPTX_PRIO_W-1:0] queue_release_prio_i,
	output wire [2:0] tx_port_core_ready_n_o,
	output reg [`LPTX_DATA_W-1:0] enq_data_o,
	output reg [`LPTX_REM_W-1:0] enq_rem_o,
	output reg [1:0] enq_port_o,
	output reg enq_valid_o,
	output reg enq_first_o,
	output reg enq_last_o,
	output reg enq_commit_o,
	output reg enq_drop_o,
	output reg [`LPTX_CNT_W-1:0] bufs_used_o
);
	// queue_release_i[0] frees one buffer at queue_release_prio_i
	reg [1:0] owner_q;
	reg owner_vld_q;
	reg [1:0] rr_q;
	reg [`LPTX_CNT_W-1:0] prio_cnt_q [0:`LPTX_NUM_PRIO-1];
	reg [`LPTX_CNT_W-1:0] bufs_q;
	wire [2:0] ready;
	wire [2:0] beat;
	wire [2:0] in_pkt;
	wire [2:0] commit;
	wire [2:0] drop;
	wire [2*3-1:0] pkt_prio;
	reg [2:0] grant;
	reg [2:0] can_start;
	reg [1:0] pick;
	reg pick_vld;
	reg done;
	reg [1:0] beat_idx;
	reg [1:0] cur;
	reg [1:0] cprio;
	reg [1:0] k;
	reg [`LPTX_PRIO_W-1:0] hp;
	wire rel;
	assign rel = queue_release_i[0];
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_port
			lptx_port u_port (
				.clk_i(clk_i),
				.rst_n_i(rst_n_i),
				.source_valid_i(~tx_port_source_valid_n_i[g]),
				.first_beat_i(~tx_port_first_beat_mark_n_i[g]),
				.last_beat_i(~tx_port_last_beat_mark_n_i[g]),
				.discard_i(~tx_port_packet_discard_n_i[g]),
				.prio_i(tx_port_payload_word_i[g*64+61 +: 2]),
				.grant_i(grant[g]),
				.can_start_i(can_start[g]),
				.ready_o(ready[g]),
				.ready_n_o(tx_port_core_ready_n_o[g]),
				.beat_o(beat[g]),
				.in_pkt_o(in_pkt[g]),
				.commit_o(commit[g]),
				.drop_o(drop[g]),
				.pkt_prio_o(pkt_prio[g*2 +: 2])
			);
		end
	endgenerate
	// port whose beat is taken this cycle; at most one port is ready
	always @* begin
		beat_idx = 2'd0;
		if (beat[1]) begin
			beat_idx = 2'd1;
		end
		if (beat[2]) begin
			beat_idx = 2'd2;
		end
	end
	// the first beat moves before the owner register can be written
	always @* begin
		if (owner_vld_q) begin
			cur = owner_q;
		end else begin
			cur = beat_idx;
		end
	end
	always @* begin
		done = |beat & (commit[cur] | drop[cur]);
	end
	// a single-beat packet ends before its priority is latched
	always @* begin
		if (in_pkt[cur]) begin
			cprio = pkt_prio[cur*2 +: 2];
		end else begin
			cprio = tx_port_payload_word_i[cur*64+61 +: 2];
		end
	end
	// round robin search among ports with a beat waiting
	always @* begin
		pick = rr_q;
		pick_vld = 1'b0;
		for (k = 2'd0; k < 2'd3; k = k + 2'd1) begin
			if (!pick_vld) begin
				if (!tx_port_source_valid_n_i[(rr_q + k) % 3]) begin
					pick = (rr_q + k) % 3;
					pick_vld = 1'b1;
				end
			end
		end
	end
	// single queue owner: one offer at a time, so two ports never overlap
	always @* begin
		grant = 3'b000;
		if (owner_vld_q) begin
			grant = 3'b000;
		end else if (|ready & ~|beat) begin
			// an open offer is kept; an idle source can hold the queue
			grant = ready;
		end else if (~|ready & pick_vld) begin
			grant[pick] = 1'b1;
		end
	end
	always @* begin
		can_start = 3'b000;
		hp = 2'b00;
		for (k = 2'd0; k < 2'd3; k = k + 2'd1) begin
			hp = tx_port_payload_word_i[k*64+61 +: 2];
			can_start[k] = (prio_cnt_q[hp] < `LPTX_PRIO_LIMIT) & (bufs_q < NUM_BUFS);
		end
	end
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			owner_q <= 2'd0;
			owner_vld_q <= 1'b0;
		end else if (owner_vld_q) begin
			if (done) begin
				owner_vld_q <= 1'b0;
			end
		end else if (|beat & ~done) begin
			owner_q <= beat_idx;
			owner_vld_q <= 1'b1;
		end
	end
	// rotate after each finished packet so no port starves
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rr_q <= 2'd0;
		end else if (done) begin
			if (cur == 2'd2) begin
				rr_q <= 2'd0;
			end else begin
				rr_q <= cur + 2'd1;
			end
		end
	end
	// release at zero is not guarded; the queue never frees an empty slot
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bufs_q <= {`LPTX_CNT_W{1'b0}};
		end else begin
			bufs_q <= bufs_q + {3'd0, |commit} - {3'd0, rel};
		end
	end
	integer i;
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (i = 0; i < `LPTX_NUM_PRIO; i = i + 1) begin
				prio_cnt_q[i] <= {`LPTX_CNT_W{1'b0}};
			end
		end else begin
			for (i = 0; i < `LPTX_NUM_PRIO; i = i + 1) begin
				prio_cnt_q[i] <= prio_cnt_q[i]
					+ {3'd0, |commit & (cprio == i)}
					- {3'd0, rel & (queue_release_prio_i == i)};
			end
		end
	end
	// output stage, control: all outputs registered
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			enq_valid_o <= 1'b0;
			enq_first_o <= 1'b0;
			enq_last_o <= 1'b0;
			enq_commit_o <= 1'b0;
			enq_drop_o <= 1'b0;
			bufs_used_o <= {`LPTX_CNT_W{1'b0}};
		end else begin
			enq_valid_o <= |beat;
			// marks held while stalled must not leak without a beat
			enq_first_o <= ~tx_port_first_beat_mark_n_i[cur] & |beat;
			enq_last_o <= ~tx_port_last_beat_mark_n_i[cur] & |beat;
			enq_commit_o <= |commit;
			enq_drop_o <= |drop;
			bufs_used_o <= bufs_q;
		end
	end
	// output stage, data
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			enq_data_o <= {`LPTX_DATA_W{1'b0}};
			enq_rem_o <= {`LPTX_REM_W{1'b0}};
			enq_port_o <= 2'd0;
		end else begin
			enq_data_o <= tx_port_payload_word_i[cur*64 +: 64];
			enq_rem_o <= tx_port_final_byte_count_i[cur*3 +: 3];
			enq_port_o <= cur;
		end
	end
endmodule // lptx_ingress

// ---- lptx_ingress_properties.sv ----
`timescale 1ns/1ps
module lptx_ingress_chk #(
	parameter NUM_BUFS = 8
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire [2:0] tx_port_source_valid_n_i,
	input wire [2:0] tx_port_core_ready_n_o,
	input wire enq_valid_o,
	input wire enq_first_o,
	input wire enq_last_o,
	input wire enq_commit_o,
	input wire enq_drop_o,
	input wire [1:0] enq_port_o,
	input wire [3:0] bufs_used_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_cause; enq_valid_o |-> $past(tx_port_source_valid_n_i) != 3'h7; endproperty
	a_cause: assert property (p_cause) else $error("beat without valid");
	property p_excl; !(enq_commit_o && enq_drop_o); endproperty
	a_excl: assert property (p_excl) else $error("commit and drop");
	property p_owner; $onehot0(~tx_port_core_ready_n_o); endproperty
	a_owner: assert property (p_owner) else $error("two owners");
	property p_bufs; bufs_used_o <= NUM_BUFS; endproperty
	a_bufs: assert property (p_bufs) else $error("buffer overrun");
	property p_first; enq_first_o |-> enq_valid_o; endproperty
	a_first: assert property (p_first) else $error("stray first");
	property p_last; enq_last_o |-> enq_valid_o; endproperty
	a_last: assert property (p_last) else $error("stray last");
	// ready must survive every non-final beat
	property p_hold; enq_valid_o && !enq_last_o |-> !tx_port_core_ready_n_o[enq_port_o]; endproperty
	a_hold: assert property (p_hold) else $error("mid packet stall");
	property p_port; enq_valid_o |-> enq_port_o != 2'h3; endproperty
	a_port: assert property (p_port) else $error("bad port");
	c_commit: cover property (enq_commit_o);
	c_drop: cover property (enq_drop_o);
	c_full: cover property (bufs_used_o == NUM_BUFS);
endmodule // lptx_ingress_chk

// ---- lptx_src_model.sv ----
`timescale 1ns/1ps
module lptx_src_model (
	input wire clk_i,
	input wire [2:0] ready_n_i,
	output reg [191:0] word_o,
	output reg [8:0] rem_o,
	output reg [2:0] first_n_o,
	output reg [2:0] last_n_o,
	output reg [2:0] valid_n_o,
	output reg [2:0] discard_n_o
);
	initial begin
		word_o = 192'h0;
		rem_o = 9'h0;
		first_n_o = 3'h7;
		last_n_o = 3'h7;
		valid_n_o = 3'h7;
		discard_n_o = 3'h7;
	end
	// gives up after 40 stalled cycles so a refusal never hangs the run
	task automatic send(input int p, input int n, input int dsc, output bit ok);
		int i;
		int w;
		begin
			ok = 1;
			for (i = 0; i < n && ok; i++) begin
				word_o[p*64+:64] = {56'h0, i[7:0]};
				rem_o[p*3+:3] = (i == n-1) ? 3'h5 : 3'h7;
				first_n_o[p] = (i != 0);
				last_n_o[p] = (i != n-1);
				discard_n_o[p] = (i != dsc);
				valid_n_o[p] = 1'b0;
				w = 0;
				do begin
					@(posedge clk_i);
					w++;
				end while (ready_n_i[p] && w < 40);
				ok = !ready_n_i[p];
				#1;
			end
			valid_n_o[p] = 1'b1;
			first_n_o[p] = 1'b1;
			last_n_o[p] = 1'b1;
			discard_n_o[p] = 1'b1;
			word_o[p*64+:64] = ~word_o[p*64+:64];
		end
	endtask
endmodule // lptx_src_model

// ---- tb_logical_port_tx_ingress.sv ----
`timescale 1ns/1ps
module tb_logical_port_tx_ingress;
	localparam int BUFS = 4;
	reg clk_i = 1'b0;
	reg rst_n_i = 1'b0;
	reg [3:0] rel = 4'h0;
	wire [191:0] word;
	wire [8:0] rem;
	wire [2:0] sof_n, eof_n, vld_n, dsc_n, rdy_n, erem;
	wire [1:0] eport;
	wire ev, ef, el, ec, ed;
	wire [3:0] used;
	int mismatches = 0;
	int compares = 0;
	int beats = 0;
	int commits = 0;
	int drops = 0;
	logic [2:0] lrem;
	bit ok;
	always #10 clk_i = ~clk_i;
	lptx_src_model src (.clk_i(clk_i), .ready_n_i(rdy_n), .word_o(word),
		.rem_o(rem), .first_n_o(sof_n), .last_n_o(eof_n), .valid_n_o(vld_n),
		.discard_n_o(dsc_n));
	lptx_ingress #(.NUM_BUFS(BUFS)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.tx_port_payload_word_i(word), .tx_port_final_byte_count_i(rem),
		.tx_port_first_beat_mark_n_i(sof_n), .tx_port_last_beat_mark_n_i(eof_n),
		.tx_port_source_valid_n_i(vld_n), .tx_port_packet_discard_n_i(dsc_n),
		.queue_release_i(rel), .queue_release_prio_i(2'h0),
		.tx_port_core_ready_n_o(rdy_n), .enq_data_o(), .enq_rem_o(erem),
		.enq_port_o(eport), .enq_valid_o(ev), .enq_first_o(ef),
		.enq_last_o(el), .enq_commit_o(ec), .enq_drop_o(ed),
		.bufs_used_o(used));
	always @(posedge clk_i) begin
		beats <= beats + ev;
		commits <= commits + ec;
		drops <= drops + ed;
		if (el) lrem <= erem;
	end
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task summarize;
		if (mismatches == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task tx(input int p, input int n, input int dsc);
		src.send(p, n, dsc, ok);
		if (!ok) begin
			mismatches++;
			summarize();
		end
		repeat (3) @(posedge clk_i);
		#1;
	endtask
	task t_basic;
		tx(0, 3, 9);
		chk("beats", 3, beats);
		chk("commits", 1, commits);
		chk("rem", 5, lrem);
	endtask
	task t_discard;
		tx(1, 4, 2);
		tx(2, 1, 0);
		chk("drops", 2, drops);
		chk("beats", 8, beats);
		chk("commits", 1, commits);
	endtask
	task t_share;
		fork
			tx(0, 2, 9);
			tx(1, 2, 9);
		join
		chk("beats", 12, beats);
		chk("commits", 3, commits);
	endtask
	task t_full;
		tx(2, 1, 9);
		chk("used", BUFS, used);
		src.send(0, 1, 9, ok);
		chk("stall", 0, ok);
		rel = 4'h1;
		@(posedge clk_i);
		#1 rel = 4'h0;
		@(posedge clk_i);
		#1;
		chk("used", BUFS - 1, used);
		tx(0, 2, 9);
		chk("commits", 5, commits);
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		t_basic();
		t_discard();
		t_share();
		t_full();
		summarize();
	end
endmodule // tb_logical_port_tx_ingress
bind lptx_ingress lptx_ingress_chk #(.NUM_BUFS(NUM_BUFS)) chk_u (
	.clk_i(clk_i), .rst_n_i(rst_n_i),
	.tx_port_source_valid_n_i(tx_port_source_valid_n_i),
	.tx_port_core_ready_n_o(tx_port_core_ready_n_o),
	.enq_valid_o(enq_valid_o), .enq_first_o(enq_first_o),
	.enq_last_o(enq_last_o), .enq_commit_o(enq_commit_o),
	.enq_drop_o(enq_drop_o), .enq_port_o(enq_port_o),
	.bufs_used_o(bufs_used_o));
